// ### hw/lcd_ctrl_consts.svh
// register indices, field positions and reset values of the lcd control block
`ifndef LCD_CTRL_CONSTS_SVH
`define LCD_CTRL_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_WHOLE_CHIP 8'h00
`define IDX_POWER_MODE 8'h04
`define IDX_SYS_STATUS 8'h05
`define IDX_ACT_RIGHT 8'h20
`define IDX_DISP_RIGHT 8'h21
`define IDX_ACT_BOTTOM 8'h30
`define IDX_DISP_BOTTOM 8'h31
`define IDX_ACT_LEFT 8'h40
`define IDX_DISP_LEFT 8'h41
`define IDX_ACT_TOP 8'h50
`define IDX_DISP_TOP 8'h51
`define IDX_CURSOR_COL 8'h60
`define IDX_CURSOR_ROW 8'h70
`define IDX_INT_SETUP 8'ha0
`define IDX_COL_CMP 8'hb0
`define IDX_ROW_CMP 8'hb1
`define IDX_CONTRAST 8'hd0
`define IDX_PATTERN 8'he0
`define IDX_FONT_CTRL 8'hf0

// interrupt setup and status fields
`define INT_KEY_FLAG 7
`define INT_TOUCH_FLAG 6
`define INT_COL_FLAG 5
`define INT_ROW_FLAG 4
`define INT_KEY_MASK 3
`define INT_TOUCH_MASK 2
`define INT_COL_MASK 1
`define INT_ROW_MASK 0

// contrast and font control fields
`define DAC_DISABLE_BIT 7
`define FONT_XFER_BIT 7
`define FONT_HALF_BIT 6
`define FONT_TYPE_LSB 4
`define FONT_FILL_BIT 3
`define FONT_ASCII_BIT 2
`define FONT_BLOCK_LSB 0

// power mode fields
`define PWR_OFF_BIT 0
`define PWR_GRAPH_BIT 1

// reset values
`define RST_WHOLE_CHIP 8'h00
`define RST_WIDTH_MAX 6'h27
`define RST_HEIGHT_MAX 8'hef
`define RST_ZERO6 6'h00
`define RST_ZERO8 8'h00
`define RST_DAC_DISABLE 1'h1
`define RST_DAC_CURRENT 5'h0f
`define RST_FONT_XFER 1'h1
`define RST_FONT_TYPE 2'h1
`define RST_FONT_BLOCK 2'h2
`define FONT_TYPE_GB256 2'h0

`endif

// ### hw/lcd_ctrl_pkg.sv
// types shared by the lcd control block
package lcd_ctrl_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic {PWR_NORMAL, PWR_OFF} power_state_e;
endpackage : lcd_ctrl_pkg

// ### hw/lcd_scan_timing.sv
// display timing generator feeding the external lcd driver
`timescale 1ns/100ps
`include "lcd_ctrl_consts.svh"
module lcd_scan_timing (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    input wire logic run,
    input wire logic wide_bus,
    input wire logic [5:0] last_col,
    input wire logic [7:0] last_row,
    input wire logic [7:0] pixel,
    output logic frame_pulse,
    output logic line_latch_pulse,
    output logic first_line_marker,
    output logic [7:0] lcd_data
);
    logic [5:0] col_r;
    logic half_r;
    logic [7:0] row_r;
    logic line_end;

    // one byte per beat on the wide bus, two nibbles on the narrow one
    assign line_end = (col_r == last_col) && (wide_bus || half_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            col_r <= 6'h00;
            half_r <= 1'b0;
            row_r <= 8'h00;
        end else if (pclk_en) begin
            if (!run) begin
                col_r <= 6'h00;
                half_r <= 1'b0;
                row_r <= 8'h00;
            end else if (line_end) begin
                col_r <= 6'h00;
                half_r <= 1'b0;
                row_r <= (row_r == last_row) ? 8'h00 : row_r + 8'h01;
            end else if (!wide_bus && !half_r) begin
                half_r <= 1'b1;
            end else begin
                half_r <= 1'b0;
                col_r <= col_r + 6'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_pulse <= 1'b0;
            line_latch_pulse <= 1'b0;
            first_line_marker <= 1'b0;
            lcd_data <= 8'h00;
        end else if (pclk_en) begin
            line_latch_pulse <= run && line_end;
            frame_pulse <= run && line_end && (row_r == last_row);
            first_line_marker <= run && (row_r == 8'h00);
            if (!run)
                lcd_data <= 8'h00;
            else if (wide_bus)
                lcd_data <= pixel;
            else
                lcd_data <= {4'h0, half_r ? pixel[3:0] : pixel[7:4]};
        end
    end
endmodule : lcd_scan_timing

// ### hw/lcd_ctrl_regs.sv
// apb register bank with interrupt, contrast, font, window and power control
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`include "lcd_ctrl_consts.svh"
// Behaviour
// - status bit 7 shows key press, read-only
// - status bit 6 shows touch, read-only
// - bit 5 set when cursor column equals compare
// - bit 4 set when cursor row equals compare
// - bit 3 masks key interrupt and busy
// - bit 2 masks touch interrupt and busy
// - bit 1 masks column compare interrupt
// - bit 0 masks row compare interrupt
// - contrast bit 7 disables dac, resets one
// - five-bit dac current, resets to 0fh
// - dac current pin released when dac disabled
// - font bit 7 enables rom transfer
// - bit 6 picks lower rom half, type 00
// - bits 5:4 select font rom type
// - graphics mode: bit 3 starts pattern fill
// - text mode: bit 2 forces single-byte ascii decode
// - bits 1:0 select ascii font block
// - off mode left on whole-chip control write, touch, key
// - strap selects pll or external clock
// - timing outputs, strap sets 8/4-bit bus
module lcd_ctrl_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic key_detect,
    input wire logic touch_detect,
    input wire logic clock_source_strap,
    input wire logic driver_bus_width_strap,
    output logic irq,
    output logic busy_enable,
    output logic [4:0] dac_current_output,
    output logic dac_current_output_oe,
    output logic ext_clock_select,
    output logic font_xfer_enable,
    output logic font_lower_half,
    output logic [1:0] font_rom_type,
    output logic ascii_only,
    output logic [1:0] ascii_block,
    output logic fill_request,
    output logic [7:0] pattern_fill_value,
    output logic off_mode,
    output logic frame_pulse,
    output logic line_latch_pulse,
    output logic first_line_marker,
    output logic [7:0] lcd_data
);
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] idx);
        unique case (idx)
            `IDX_WHOLE_CHIP, `IDX_POWER_MODE, `IDX_SYS_STATUS, `IDX_ACT_RIGHT, `IDX_DISP_RIGHT,
            `IDX_ACT_BOTTOM, `IDX_DISP_BOTTOM, `IDX_ACT_LEFT, `IDX_DISP_LEFT, `IDX_ACT_TOP,
            `IDX_DISP_TOP, `IDX_CURSOR_COL, `IDX_CURSOR_ROW, `IDX_INT_SETUP, `IDX_COL_CMP,
            `IDX_ROW_CMP, `IDX_CONTRAST, `IDX_PATTERN, `IDX_FONT_CTRL: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    logic [7:0] idx;
    logic hit;
    logic access;
    logic wr;
    logic [7:0] wd;

    assign idx = paddr[9:2];
    assign hit = (paddr[1:0] == 2'h0) && is_mapped(idx);
    assign access = psel && penable && pclk_en;
    assign wr = access && pwrite && hit;
    assign wd = pwdata[7:0];
    assign pready = pclk_en;
    assign pslverr = psel && penable && !hit;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] whole_chip_control_r;
    logic graph_mode_r;
    logic [5:0] act_right_r;
    logic [5:0] disp_right_r;
    logic [7:0] act_bottom_r;
    logic [7:0] disp_bottom_r;
    logic [5:0] act_left_r;
    logic [5:0] disp_left_r;
    logic [7:0] act_top_r;
    logic [7:0] disp_top_r;
    logic [5:0] cursor_col_r;
    logic [7:0] cursor_row_r;
    logic [3:0] int_mask_r;
    logic [5:0] col_cmp_r;
    logic [7:0] row_cmp_r;
    logic dac_disable_r;
    logic [4:0] dac_current_r;
    logic [7:0] pattern_r;
    logic [7:0] font_ctrl_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            whole_chip_control_r <= `RST_WHOLE_CHIP;
            graph_mode_r <= 1'b0;
            act_right_r <= `RST_WIDTH_MAX;
            disp_right_r <= `RST_WIDTH_MAX;
            act_bottom_r <= `RST_HEIGHT_MAX;
            disp_bottom_r <= `RST_HEIGHT_MAX;
            act_left_r <= `RST_ZERO6;
            disp_left_r <= `RST_ZERO6;
            act_top_r <= `RST_ZERO8;
            disp_top_r <= `RST_ZERO8;
            cursor_col_r <= `RST_ZERO6;
            cursor_row_r <= `RST_ZERO8;
            col_cmp_r <= `RST_ZERO6;
            row_cmp_r <= `RST_ZERO8;
            pattern_r <= `RST_ZERO8;
        end else if (wr) begin
            unique case (idx)
                `IDX_WHOLE_CHIP: whole_chip_control_r <= wd;
                `IDX_POWER_MODE: graph_mode_r <= wd[`PWR_GRAPH_BIT];
                `IDX_ACT_RIGHT: act_right_r <= wd[5:0];
                `IDX_DISP_RIGHT: disp_right_r <= wd[5:0];
                `IDX_ACT_BOTTOM: act_bottom_r <= wd;
                `IDX_DISP_BOTTOM: disp_bottom_r <= wd;
                `IDX_ACT_LEFT: act_left_r <= wd[5:0];
                `IDX_DISP_LEFT: disp_left_r <= wd[5:0];
                `IDX_ACT_TOP: act_top_r <= wd;
                `IDX_DISP_TOP: disp_top_r <= wd;
                `IDX_CURSOR_COL: cursor_col_r <= wd[5:0];
                `IDX_CURSOR_ROW: cursor_row_r <= wd;
                `IDX_COL_CMP: col_cmp_r <= wd[5:0];
                `IDX_ROW_CMP: row_cmp_r <= wd;
                `IDX_PATTERN: pattern_r <= wd;
                default: ;
            endcase
        end
    end

    // interrupt masks; status bits of the same register are read-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            int_mask_r <= 4'h0;
        else if (wr && idx == `IDX_INT_SETUP)
            int_mask_r <= wd[3:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_disable_r <= `RST_DAC_DISABLE;
            dac_current_r <= `RST_DAC_CURRENT;
        end else if (wr && idx == `IDX_CONTRAST) begin
            dac_disable_r <= wd[`DAC_DISABLE_BIT];
            dac_current_r <= wd[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            font_ctrl_r <= {`RST_FONT_XFER, 1'b0, `RST_FONT_TYPE, 2'b00, `RST_FONT_BLOCK};
            fill_request <= 1'b0;
        end else if (pclk_en) begin
            fill_request <= wr && idx == `IDX_FONT_CTRL && wd[`FONT_FILL_BIT] && graph_mode_r;
            if (wr && idx == `IDX_FONT_CTRL)
                font_ctrl_r <= wd;
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    logic key_r;
    logic touch_r;
    logic col_eq_r;
    logic row_eq_r;
    logic [3:0] status;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_r <= 1'b0;
            touch_r <= 1'b0;
            col_eq_r <= 1'b0;
            row_eq_r <= 1'b0;
        end else if (pclk_en) begin
            key_r <= key_detect;
            touch_r <= touch_detect;
            col_eq_r <= (cursor_col_r == col_cmp_r);
            row_eq_r <= (cursor_row_r == row_cmp_r);
        end
    end

    assign status = {key_r, touch_r, col_eq_r, row_eq_r};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq <= 1'b0;
        else if (pclk_en)
            irq <= |(status & int_mask_r);
    end

    assign busy_enable = |int_mask_r;

    // ------------------------------------------------------------
    // power mode and straps
    // ------------------------------------------------------------
    lcd_ctrl_pkg::power_state_e pwr_r;
    logic straps_taken_r;
    logic wide_bus_r;
    logic wake;

    assign wake = (wr && idx == `IDX_WHOLE_CHIP) || touch_r || key_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pwr_r <= lcd_ctrl_pkg::PWR_NORMAL;
        else if (pclk_en) begin
            unique case (pwr_r)
                lcd_ctrl_pkg::PWR_NORMAL:
                    if (wr && idx == `IDX_POWER_MODE && wd[`PWR_OFF_BIT])
                        pwr_r <= lcd_ctrl_pkg::PWR_OFF;
                lcd_ctrl_pkg::PWR_OFF:
                    if (wake)
                        pwr_r <= lcd_ctrl_pkg::PWR_NORMAL;
            endcase
        end
    end

    assign off_mode = (pwr_r == lcd_ctrl_pkg::PWR_OFF);

    // straps are caught once, on the first enabled edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            straps_taken_r <= 1'b0;
            ext_clock_select <= 1'b0;
            wide_bus_r <= 1'b0;
        end else if (pclk_en && !straps_taken_r) begin
            straps_taken_r <= 1'b1;
            ext_clock_select <= clock_source_strap;
            wide_bus_r <= driver_bus_width_strap;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [7:0] rd;

    always_comb begin
        rd = 8'h00;
        unique case (idx)
            `IDX_WHOLE_CHIP: rd = whole_chip_control_r;
            `IDX_POWER_MODE: rd = {6'h00, graph_mode_r, off_mode};
            `IDX_SYS_STATUS: rd = {5'h00, wide_bus_r, ext_clock_select, straps_taken_r};
            `IDX_ACT_RIGHT: rd = {2'h0, act_right_r};
            `IDX_DISP_RIGHT: rd = {2'h0, disp_right_r};
            `IDX_ACT_BOTTOM: rd = act_bottom_r;
            `IDX_DISP_BOTTOM: rd = disp_bottom_r;
            `IDX_ACT_LEFT: rd = {2'h0, act_left_r};
            `IDX_DISP_LEFT: rd = {2'h0, disp_left_r};
            `IDX_ACT_TOP: rd = act_top_r;
            `IDX_DISP_TOP: rd = disp_top_r;
            `IDX_CURSOR_COL: rd = {2'h0, cursor_col_r};
            `IDX_CURSOR_ROW: rd = cursor_row_r;
            `IDX_INT_SETUP: rd = {status, int_mask_r};
            `IDX_COL_CMP: rd = {2'h0, col_cmp_r};
            `IDX_ROW_CMP: rd = row_cmp_r;
            `IDX_CONTRAST: rd = {dac_disable_r, 2'h0, dac_current_r};
            `IDX_PATTERN: rd = pattern_r;
            `IDX_FONT_CTRL: rd = font_ctrl_r;
            default: rd = 8'h00;
        endcase
    end

    // data is captured in the setup cycle so the access cycle presents a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (pclk_en && psel && !penable && !pwrite)
            prdata <= {24'h00_0000, hit ? rd : 8'h00};
    end

    // ------------------------------------------------------------
    // outputs to dac, font logic and display timing
    // ------------------------------------------------------------
    assign dac_current_output = dac_current_r;
    assign dac_current_output_oe = !dac_disable_r;
    assign font_xfer_enable = font_ctrl_r[`FONT_XFER_BIT];
    assign font_rom_type = font_ctrl_r[`FONT_TYPE_LSB +: 2];
    assign font_lower_half = font_ctrl_r[`FONT_HALF_BIT] && (font_rom_type == `FONT_TYPE_GB256);
    assign ascii_only = font_ctrl_r[`FONT_ASCII_BIT] && !graph_mode_r;
    assign ascii_block = font_ctrl_r[`FONT_BLOCK_LSB +: 2];
    assign pattern_fill_value = pattern_r;

    lcd_scan_timing u_timing (
        .pclk(pclk),
        .presetn(presetn),
        .pclk_en(pclk_en),
        .run(!off_mode && straps_taken_r),
        .wide_bus(wide_bus_r),
        .last_col(disp_right_r),
        .last_row(disp_bottom_r),
        .pixel(pattern_r),
        .frame_pulse(frame_pulse),
        .line_latch_pulse(line_latch_pulse),
        .first_line_marker(first_line_marker),
        .lcd_data(lcd_data)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_key_flag: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && pclk_en |=> status[3] == $past(key_detect))
        else $error("key flag does not follow key input");
    chk_touch_flag: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && pclk_en |=> status[2] == $past(touch_detect))
        else $error("touch flag does not follow touch input");
    chk_col_compare: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && pclk_en
        |=> col_eq_r == ($past(cursor_col_r) == $past(col_cmp_r)))
        else $error("column compare flag wrong");
    chk_row_compare: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && pclk_en
        |=> row_eq_r == ($past(cursor_row_r) == $past(row_cmp_r)))
        else $error("row compare flag wrong");
    chk_irq_masking: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && pclk_en |=> irq == |($past(status) & $past(int_mask_r)))
        else $error("interrupt does not follow masked status");
    chk_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && idx == `IDX_INT_SETUP |=> int_mask_r == $past(wd[3:0]) && busy_enable == |$past(wd[3:0]))
        else $error("mask write not taken");
    chk_dac_release: assert property (@(posedge pclk) disable iff (!presetn)
        wr && idx == `IDX_CONTRAST && wd[`DAC_DISABLE_BIT] |=> !dac_current_output_oe)
        else $error("dac pin still driven when disabled");
    chk_fill_start: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(fill_request) |-> $past(wr) && $past(idx) == `IDX_FONT_CTRL && $past(graph_mode_r)
        && $past(wd[`FONT_FILL_BIT]))
        else $error("fill request without graphics write");
    chk_wake_up: assert property (@(posedge pclk) disable iff (!presetn)
        pclk_en && off_mode && (touch_r || key_r) |=> !off_mode)
        else $error("off mode not left on wake event");
    chk_strap_clock: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && pclk_en && !straps_taken_r |=> ext_clock_select == $past(clock_source_strap))
        else $error("clock strap not captured");
    chk_font_reset: assert property (@(posedge pclk)
        $rose(presetn) |-> font_ctrl_r == 8'h92 && dac_disable_r && dac_current_r == 5'h0f)
        else $error("font or contrast reset value wrong");
endmodule : lcd_ctrl_regs

// ### verification/panel_event_model.sv
// far-side event sources and strap pins feeding the register block
`timescale 1ns/100ps
module panel_event_model (
    input wire logic pclk,
    input wire logic key_req,
    input wire logic touch_req,
    input wire logic straps_high,
    output logic key_detect,
    output logic touch_detect,
    output logic clock_source_strap,
    output logic driver_bus_width_strap
);
    initial begin
        key_detect = 1'b0;
        touch_detect = 1'b0;
    end
    // both straps follow the bench's choice
    assign clock_source_strap = straps_high;
    assign driver_bus_width_strap = straps_high;
    // key and touch are synchronous levels, launched just after the edge
    always @(posedge pclk) begin
        key_detect <= key_req;
        touch_detect <= touch_req;
    end
endmodule : panel_event_model

// ### verification/tb_lcd_ctrl_regs.sv
// self-checking bench for the lcd control register block
`timescale 1ns/100ps
`include "lcd_ctrl_consts.svh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module tb_lcd_ctrl_regs;
    logic pclk, presetn, pclk_en, psel, penable, pwrite, pready, pslverr, key_req, touch_req;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata;
    logic key_detect, touch_detect, clock_source_strap, driver_bus_width_strap, irq, busy_enable;
    logic [4:0] dac_current_output;
    logic dac_current_output_oe, ext_clock_select, font_xfer_enable, font_lower_half, ascii_only;
    logic [1:0] font_rom_type, ascii_block;
    logic fill_request, off_mode, frame_pulse, line_latch_pulse, first_line_marker;
    logic [7:0] pattern_fill_value, lcd_data, rv;
    logic ev, straps_high;
    int error_cnt, comparisons, n;

    lcd_ctrl_regs dut_u (.pclk, .presetn, .pclk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .key_detect, .touch_detect, .clock_source_strap, .driver_bus_width_strap,
        .irq, .busy_enable, .dac_current_output, .dac_current_output_oe, .ext_clock_select,
        .font_xfer_enable, .font_lower_half, .font_rom_type, .ascii_only, .ascii_block, .fill_request,
        .pattern_fill_value, .off_mode, .frame_pulse, .line_latch_pulse, .first_line_marker, .lcd_data);
    panel_event_model far_u (.pclk, .key_req, .touch_req, .straps_high, .key_detect, .touch_detect,
        .clock_source_strap, .driver_bus_width_strap);

    always #50 pclk = ~pclk;

    task results;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    // one apb transfer: setup, then access held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd,
            output logic err);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            error_cnt++;
            results();
        end
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask : wr

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string nm);
        logic [7:0] r;
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
        `CHK(nm, exp, r)
    endtask : rdchk

    task automatic settle(input int c);
        repeat (c) @(posedge pclk);
        #1;
    endtask : settle

    // watch fill_request for a few cycles after a font control write
    task automatic fill_seen(output logic s);
        s = 1'b0;
        repeat (4) begin
            #1;
            if (fill_request === 1'b1) s = 1'b1;
            @(posedge pclk);
        end
    endtask : fill_seen

    initial begin
        pclk = 0; presetn = 0; pclk_en = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; key_req = 0; touch_req = 0; error_cnt = 0; comparisons = 0;
        straps_high = 1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        settle(2);
        `CHK("dac_current", 5'h0f, dac_current_output)
        `CHK("dac_oe", 1'b0, dac_current_output_oe)
        `CHK("ext_clock", 1'b1, ext_clock_select)
        `CHK("font_type", 2'h1, font_rom_type)
        rdchk(`IDX_CONTRAST, 8'h8f, "contrast");
        rdchk(`IDX_FONT_CTRL, 8'h92, "font_ctrl");
        wr(`IDX_CONTRAST, 8'h15);
        settle(1);
        `CHK("dac_oe_on", 1'b1, dac_current_output_oe)
        `CHK("dac_current_w", 5'h15, dac_current_output)
        rdchk(`IDX_CONTRAST, 8'h15, "contrast_w");
        wr(`IDX_CONTRAST, 8'h95);
        settle(1);
        `CHK("dac_oe_off", 1'b0, dac_current_output_oe)
        // cursor stays inside the active window
        wr(`IDX_CURSOR_COL, 8'h05);
        wr(`IDX_CURSOR_ROW, 8'h10);
        wr(`IDX_COL_CMP, 8'h06);
        wr(`IDX_ROW_CMP, 8'h11);
        settle(2);
        rdchk(`IDX_INT_SETUP, 8'h00, "status_idle");
        touch_req <= 1'b1;
        settle(3);
        rdchk(`IDX_INT_SETUP, 8'h40, "status_touch");
        `CHK("irq_masked", 1'b0, irq)
        wr(`IDX_INT_SETUP, 8'hf4);
        settle(3);
        `CHK("irq_touch", 1'b1, irq)
        `CHK("busy_touch", 1'b1, busy_enable)
        rdchk(`IDX_INT_SETUP, 8'h44, "status_ro");
        touch_req <= 1'b0;
        settle(3);
        `CHK("irq_release", 1'b0, irq)
        key_req <= 1'b1;
        wr(`IDX_INT_SETUP, 8'h08);
        settle(3);
        `CHK("irq_key", 1'b1, irq)
        rdchk(`IDX_INT_SETUP, 8'h88, "status_key");
        key_req <= 1'b0;
        wr(`IDX_INT_SETUP, 8'h03);
        settle(3);
        `CHK("irq_cmp_off", 1'b0, irq)
        wr(`IDX_COL_CMP, 8'h05);
        settle(3);
        `CHK("irq_col", 1'b1, irq)
        rdchk(`IDX_INT_SETUP, 8'h23, "status_col");
        wr(`IDX_COL_CMP, 8'h06);
        wr(`IDX_ROW_CMP, 8'h10);
        settle(3);
        rdchk(`IDX_INT_SETUP, 8'h13, "status_row");
        `CHK("irq_row", 1'b1, irq)
        wr(`IDX_INT_SETUP, 8'h02);
        settle(3);
        `CHK("irq_row_mask", 1'b0, irq)
        wr(`IDX_INT_SETUP, 8'h00);
        settle(1);
        `CHK("busy_off", 1'b0, busy_enable)
        for (int t = 0; t < 3; t++) begin
            for (int b = 0; b < 4; b++) begin
                wr(`IDX_FONT_CTRL, {2'b11, 2'(t), 2'b01, 2'(b)});
                settle(1);
                `CHK("font_type", 2'(t), font_rom_type)
                `CHK("ascii_block", 2'(b), ascii_block)
                `CHK("lower_half", (t == 0), font_lower_half)
                `CHK("ascii_only", 1'b1, ascii_only)
                `CHK("xfer_on", 1'b1, font_xfer_enable)
            end
        end
        wr(`IDX_FONT_CTRL, 8'h08);
        fill_seen(ev);
        `CHK("fill_text", 1'b0, ev)
        `CHK("xfer_off", 1'b0, font_xfer_enable)
        `CHK("ascii_off", 1'b0, ascii_only)
        wr(`IDX_POWER_MODE, 8'h02);
        wr(`IDX_FONT_CTRL, 8'h08);
        fill_seen(ev);
        `CHK("fill_graph", 1'b1, ev)
        for (int s = 0; s < 3; s++) begin
            wr(`IDX_POWER_MODE, 8'h03);
            settle(1);
            `CHK("off_enter", 1'b1, off_mode)
            if (s == 0) wr(`IDX_WHOLE_CHIP, 8'h00);
            if (s == 1) touch_req <= 1'b1;
            if (s == 2) key_req <= 1'b1;
            settle(4);
            `CHK("off_wake", 1'b0, off_mode)
            touch_req <= 1'b0;
            key_req <= 1'b0;
            settle(3);
        end
        apb(1'b0, 8'hff, 8'h00, rv, ev);
        `CHK("unmapped_err", 1'b1, ev)
        `CHK("unmapped_data", 8'h00, rv)
        wr(`IDX_DISP_RIGHT, 8'h27);
        wr(`IDX_DISP_BOTTOM, 8'hef);
        wr(`IDX_PATTERN, 8'ha5);
        settle(1);
        n = 0;
        while (line_latch_pulse !== 1'b1 && n < 200) begin
            settle(1);
            n++;
        end
        `CHK("line_latch", 1'b1, line_latch_pulse)
        `CHK("pattern", 8'ha5, pattern_fill_value)
        `CHK("lcd_data_wide", 8'ha5, lcd_data)
        n = 0;
        while (frame_pulse !== 1'b1 && n < 12000) begin
            settle(1);
            n++;
        end
        `CHK("frame", 1'b1, frame_pulse)
        settle(1);
        `CHK("first_line", 1'b1, first_line_marker)
        // second reset with both straps low: pll clock, narrow driver bus
        @(posedge pclk);
        straps_high <= 1'b0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        settle(2);
        `CHK("pll_clock", 1'b0, ext_clock_select)
        rdchk(`IDX_SYS_STATUS, 8'h01, "sys_status_low");
        wr(`IDX_PATTERN, 8'ha5);
        settle(1);
        n = 0;
        while (line_latch_pulse !== 1'b1 && n < 200) begin
            settle(1);
            n++;
        end
        `CHK("line_latch_narrow", 1'b1, line_latch_pulse)
        `CHK("lcd_data_narrow", 8'h05, lcd_data)
        results();
    end
endmodule : tb_lcd_ctrl_regs
